// ==== jdbg_defines.svh ====
`ifndef JDBG_DEFINES_SVH
`define JDBG_DEFINES_SVH
// instruction register codes and width
`define JDBG_IR_W        4
`define JDBG_IR_DEVSEL   4'h2
`define JDBG_IR_BUS      4'h3
`define JDBG_IR_BYPASS   4'hf
`define JDBG_IR_CAPTURE  4'h1
// scan register lengths and device-select reserved bit count
`define JDBG_BUS_SCAN_W  42
`define JDBG_DSEL_W      32
`define JDBG_DSEL_RSVD   7
// bus-access scan field positions
`define JDBG_F_EXEC      0
`define JDBG_F_DIR       1
`define JDBG_F_ADDR_LO   2
`define JDBG_F_DATA_LO   10
// register addresses
`define JDBG_A_XCHG      8'h04
`define JDBG_A_CSR       8'h05
`define JDBG_A_SEGADDR   8'h06
`define JDBG_A_SEGWIN    8'h07
`define JDBG_A_PCLO      8'h08
`define JDBG_A_PCHI      8'h09
// debug_control_status field positions
`define JDBG_CSR_DBGMODE 0
`define JDBG_CSR_BRK     1
`define JDBG_CSR_RSTSEEN 2
`define JDBG_CSR_DREQ    3
// segment address auto-increment
`define JDBG_SEG_AINC    31
`define JDBG_SEG_STEP    31'h4
// reset values
`define JDBG_RST_SEGADDR 32'h0000_0000
`define JDBG_RST_XCHG    32'h0000_0000
`endif

// ==== jdbg_pkg.sv ====
// Purpose: types shared by the debug access port
// Assumes: constants come from jdbg_defines.svh
// Notes:   request and result travel as packed structs
package jdbg_pkg;
  typedef enum logic [1:0] {
    ERR_NONE,
    ERR_ADDR,
    ERR_RO,
    ERR_SEG
  } jdbg_err_e;

  typedef struct packed {
    logic [31:0] data;
    logic [7:0]  addr;
    logic        dir;
    logic        exec;
  } jdbg_req_s;

  typedef struct packed {
    logic [31:0] data;
    jdbg_err_e   err;
    logic        ok;
    logic        valid;
  } jdbg_rsp_s;

  typedef enum {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
  } jdbg_tap_e;
endpackage

// ==== jdbg_port.sv ====
// Purpose: jtag debug access port, bus-access transactions into the core
// Assumes: jtag pins are asynchronous to mclk; tck far slower than mclk
// Notes:   dir 1 = read; results pipelined by one scan
// Summary of operation
// - select device first; low seven bits read zero
// - next scan shifts valid, ok and error
// - good read returns valid, ok, data
// - control/status at 0x05 shows debug mode
// - exchange writes feed instructions, valid means executed
// - core load takes probe exchange write
// - core store read back through exchange
// - segment address 0x06, top bit enables increment
// - window 0x07 reads segment word at address
// - 0x08 gives low half of sample
// - 0x09 gives high half of sample
// - scan-out carries previous transaction's result
// - status shows breakpoint hit and reset occurred
`timescale 1ns/1ps
`include "jdbg_defines.svh"
module jdbg_port #(
  parameter logic [24:0] DEV_NUM = 25'h0
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // jtag pins
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output      logic        tdo,
  output      logic        tdo_oe,
  // core status
  input  wire logic        debug_mode,
  input  wire logic        bkpt_event,
  input  wire logic        reset_event,
  output      logic        debug_req,
  input  wire logic [63:0] pc_sample,
  // instruction/data exchange with the core
  output      logic [31:0] xchg_data,
  output      logic        xchg_valid,
  input  wire logic        xchg_take,
  input  wire logic        core_store,
  input  wire logic [31:0] core_store_data,
  // debug register segment
  output      logic [31:0] seg_addr,
  output      logic        seg_rd,
  output      logic        seg_wr,
  output      logic [31:0] seg_wdata,
  input  wire logic [31:0] seg_rdata,
  input  wire logic        seg_err
);
  logic [2:0]                  tck_q;
  logic [1:0]                  tms_q;
  logic [1:0]                  tdi_q;
  logic                        tck_rise;
  logic                        tck_fall;
  jdbg_pkg::jdbg_tap_e         tap;
  logic [`JDBG_IR_W-1:0]       ir;
  logic [`JDBG_IR_W-1:0]       ir_sh;
  logic [`JDBG_BUS_SCAN_W-1:0] dr_sh;
  logic [24:0]                 dev_sel;
  logic                        busy;
  jdbg_pkg::jdbg_req_s         req;
  jdbg_pkg::jdbg_req_s         scan_req;
  jdbg_pkg::jdbg_rsp_s         res;
  jdbg_pkg::jdbg_rsp_s         next_res;
  logic                        done;
  logic                        brk_flag;
  logic                        rst_seen_flag;
  logic [31:0]                 csr_rd;
  logic [31:0]                 pc_hi_hold;
  logic                        seg_go;

  // two flops on every pin; tck_q[2] is only an edge history of tck_q[1]
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      tck_q <= 3'h0;
      tms_q <= 2'h0;
      tdi_q <= 2'h0;
    end
    else
    begin
      tck_q <= {tck_q[1:0], tck};
      tms_q <= {tms_q[0], tms};
      tdi_q <= {tdi_q[0], tdi};
    end
  assign tck_rise = tck_q[1] & ~tck_q[2];
  assign tck_fall = ~tck_q[1] & tck_q[2];
  function automatic jdbg_pkg::jdbg_tap_e tap_next(input jdbg_pkg::jdbg_tap_e s, input logic m);
    case (s)
      jdbg_pkg::TLR:    tap_next = m ? jdbg_pkg::TLR    : jdbg_pkg::RTI;
      jdbg_pkg::RTI:    tap_next = m ? jdbg_pkg::SEL_DR : jdbg_pkg::RTI;
      jdbg_pkg::SEL_DR: tap_next = m ? jdbg_pkg::SEL_IR : jdbg_pkg::CAP_DR;
      jdbg_pkg::CAP_DR: tap_next = m ? jdbg_pkg::EX1_DR : jdbg_pkg::SH_DR;
      jdbg_pkg::SH_DR:  tap_next = m ? jdbg_pkg::EX1_DR : jdbg_pkg::SH_DR;
      jdbg_pkg::EX1_DR: tap_next = m ? jdbg_pkg::UP_DR  : jdbg_pkg::PA_DR;
      jdbg_pkg::PA_DR:  tap_next = m ? jdbg_pkg::EX2_DR : jdbg_pkg::PA_DR;
      jdbg_pkg::EX2_DR: tap_next = m ? jdbg_pkg::UP_DR  : jdbg_pkg::SH_DR;
      jdbg_pkg::UP_DR:  tap_next = m ? jdbg_pkg::SEL_DR : jdbg_pkg::RTI;
      jdbg_pkg::SEL_IR: tap_next = m ? jdbg_pkg::TLR    : jdbg_pkg::CAP_IR;
      jdbg_pkg::CAP_IR: tap_next = m ? jdbg_pkg::EX1_IR : jdbg_pkg::SH_IR;
      jdbg_pkg::SH_IR:  tap_next = m ? jdbg_pkg::EX1_IR : jdbg_pkg::SH_IR;
      jdbg_pkg::EX1_IR: tap_next = m ? jdbg_pkg::UP_IR  : jdbg_pkg::PA_IR;
      jdbg_pkg::PA_IR:  tap_next = m ? jdbg_pkg::EX2_IR : jdbg_pkg::PA_IR;
      jdbg_pkg::EX2_IR: tap_next = m ? jdbg_pkg::UP_IR  : jdbg_pkg::SH_IR;
      jdbg_pkg::UP_IR:  tap_next = m ? jdbg_pkg::SEL_DR : jdbg_pkg::RTI;
      default:          tap_next = jdbg_pkg::TLR;
    endcase
  endfunction
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      tap <= jdbg_pkg::TLR;
    else if (tck_rise)
      tap <= tap_next(tap, tms_q[1]);
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      ir    <= `JDBG_IR_BYPASS;
      ir_sh <= `JDBG_IR_BYPASS;
    end
    else if (tck_rise)
    begin
      if (tap == jdbg_pkg::TLR)
        ir <= `JDBG_IR_BYPASS;
      else if (tap == jdbg_pkg::UP_IR)
        ir <= ir_sh;
      if (tap == jdbg_pkg::CAP_IR)
        ir_sh <= `JDBG_IR_CAPTURE;
      else if (tap == jdbg_pkg::SH_IR)
        ir_sh <= {tdi_q[1], ir_sh[`JDBG_IR_W-1:1]};
    end
  // data register shifter, right shift, tdi enters at the active length
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      dr_sh <= '0;
    else if (tck_rise)
    begin
      if (tap == jdbg_pkg::CAP_DR)
      begin
        if (ir == `JDBG_IR_BUS)
          dr_sh <= {res.data, 6'h00, res.err, res.ok, res.valid};
        else if (ir == `JDBG_IR_DEVSEL)
          dr_sh <= {10'h000, dev_sel, 7'h00};
        else
          dr_sh <= '0;
      end
      else if (tap == jdbg_pkg::SH_DR)
      begin
        if (ir == `JDBG_IR_BUS)
          dr_sh <= {tdi_q[1], dr_sh[`JDBG_BUS_SCAN_W-1:1]};
        else if (ir == `JDBG_IR_DEVSEL)
          dr_sh <= {10'h000, tdi_q[1], dr_sh[`JDBG_DSEL_W-1:1]};
        else
          dr_sh <= {{(`JDBG_BUS_SCAN_W-1){1'b0}}, tdi_q[1]};
      end
    end

  // device number kept above the reserved bits
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      dev_sel <= 25'h0;
    else if (tck_rise && tap == jdbg_pkg::UP_DR && ir == `JDBG_IR_DEVSEL)
      dev_sel <= dr_sh[`JDBG_DSEL_W-1:`JDBG_DSEL_RSVD];
  // tdo changes on the falling tck edge
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo    <= (tap == jdbg_pkg::SH_IR) ? ir_sh[0] : dr_sh[0];
      tdo_oe <= (tap == jdbg_pkg::SH_IR) || (tap == jdbg_pkg::SH_DR);
    end

  // transaction accept; a request while busy is dropped and must be repeated
  assign scan_req = jdbg_pkg::jdbg_req_s'(dr_sh);
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      busy <= 1'b0;
      req  <= '0;
    end
    else if (tck_rise && tap == jdbg_pkg::UP_DR && ir == `JDBG_IR_BUS && scan_req.exec && !busy
             && dev_sel == DEV_NUM)
    begin
      busy <= 1'b1;
      req  <= scan_req;
    end
    else if (done)
      busy <= 1'b0;
  // exchange write completes only once the core has taken it
  assign done = busy && !(req.addr == `JDBG_A_XCHG && !req.dir && !xchg_take);
  assign seg_go = done && req.addr == `JDBG_A_SEGWIN;
  // sticky event flags, an event beats a clearing write
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      brk_flag      <= 1'b0;
      rst_seen_flag <= 1'b0;
      debug_req     <= 1'b0;
    end
    else
    begin
      if (bkpt_event)
        brk_flag <= 1'b1;
      else if (done && !req.dir && req.addr == `JDBG_A_CSR && req.data[`JDBG_CSR_BRK])
        brk_flag <= 1'b0;
      if (reset_event)
        rst_seen_flag <= 1'b1;
      else if (done && !req.dir && req.addr == `JDBG_A_CSR && req.data[`JDBG_CSR_RSTSEEN])
        rst_seen_flag <= 1'b0;
      if (done && !req.dir && req.addr == `JDBG_A_CSR)
        debug_req <= req.data[`JDBG_CSR_DREQ];
    end
  assign csr_rd = {28'h0000000, debug_req, rst_seen_flag, brk_flag, debug_mode};
  // probe write loads the exchange for the core; core store fills it
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      xchg_data  <= `JDBG_RST_XCHG;
      xchg_valid <= 1'b0;
    end
    else
    begin
      if (core_store)
        xchg_data <= core_store_data;
      else if (tck_rise && tap == jdbg_pkg::UP_DR && ir == `JDBG_IR_BUS && scan_req.exec && !busy
               && dev_sel == DEV_NUM && scan_req.addr == `JDBG_A_XCHG && !scan_req.dir)
        xchg_data <= scan_req.data;
      if (busy && req.addr == `JDBG_A_XCHG && !req.dir && !xchg_take)
        xchg_valid <= 1'b1;
      else
        xchg_valid <= 1'b0;
    end

  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      seg_addr <= `JDBG_RST_SEGADDR;
    else if (done && !req.dir && req.addr == `JDBG_A_SEGADDR)
      seg_addr <= req.data;
    else if (seg_go && seg_addr[`JDBG_SEG_AINC])
      seg_addr[30:0] <= seg_addr[30:0] + `JDBG_SEG_STEP;
  assign seg_rd    = seg_go && req.dir;
  assign seg_wr    = seg_go && !req.dir;
  assign seg_wdata = req.data;
  // high half frozen when the low half is read
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      pc_hi_hold <= 32'h0;
    else if (done && req.dir && req.addr == `JDBG_A_PCLO)
      pc_hi_hold <= pc_sample[63:32];
  always_comb
  begin
    next_res = '{data: 32'h0, err: jdbg_pkg::ERR_NONE, ok: 1'b1, valid: 1'b1};
    case (req.addr)
      `JDBG_A_XCHG:    next_res.data = xchg_data;
      `JDBG_A_CSR:     next_res.data = csr_rd;
      `JDBG_A_SEGADDR: next_res.data = seg_addr;
      `JDBG_A_SEGWIN:
      begin
        next_res.data = seg_rdata;
        if (seg_err)
        begin
          next_res.ok  = 1'b0;
          next_res.err = jdbg_pkg::ERR_SEG;
        end
      end
      `JDBG_A_PCLO:    next_res.data = pc_sample[31:0];
      `JDBG_A_PCHI:    next_res.data = pc_hi_hold;
      default:
      begin
        next_res.ok  = 1'b0;
        next_res.err = jdbg_pkg::ERR_ADDR;
      end
    endcase
    if (!req.dir && (req.addr == `JDBG_A_PCLO || req.addr == `JDBG_A_PCHI))
    begin
      next_res.ok  = 1'b0;
      next_res.err = jdbg_pkg::ERR_RO;
    end
  end

  // valid cleared on accept, set on completion
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      res <= '0;
    else if (done)
      res <= next_res;
    else if (tck_rise && tap == jdbg_pkg::UP_DR && ir == `JDBG_IR_BUS && scan_req.exec && !busy
             && dev_sel == DEV_NUM)
      res.valid <= 1'b0;

  a_dsel_low: assert property (@(posedge mclk) disable iff (!arst_n)
    (tck_rise && tap == jdbg_pkg::CAP_DR && ir == `JDBG_IR_DEVSEL) |=> dr_sh[6:0] == 7'h00)
    else $error("device select reserved bits not zero");
  a_done_valid: assert property (@(posedge mclk) disable iff (!arst_n)
    done |=> res.valid && !busy)
    else $error("completion did not raise valid");
  a_read_ok: assert property (@(posedge mclk) disable iff (!arst_n)
    (done && req.addr == `JDBG_A_CSR) |=> res.ok && res.data == $past(csr_rd))
    else $error("read did not return register");
  a_debug_mode_flag: assert property (@(posedge mclk) disable iff (!arst_n)
    (done && req.addr == `JDBG_A_CSR) |=> res.data[`JDBG_CSR_DBGMODE] == $past(debug_mode))
    else $error("debug mode flag wrong");
  a_xchg_wait: assert property (@(posedge mclk) disable iff (!arst_n)
    (busy && req.addr == `JDBG_A_XCHG && !req.dir && !xchg_take) |=> busy && !res.valid)
    else $error("instruction write completed early");
  a_seg_incr: assert property (@(posedge mclk) disable iff (!arst_n)
    (seg_go && seg_addr[31]) |=> seg_addr[30:0] == $past(seg_addr[30:0]) + 31'h4)
    else $error("segment address not incremented");
  a_pc_pair: assert property (@(posedge mclk) disable iff (!arst_n)
    (done && req.dir && req.addr == `JDBG_A_PCLO) |=> pc_hi_hold == $past(pc_sample[63:32]))
    else $error("high sample half not frozen");
  a_scan_prev: assert property (@(posedge mclk) disable iff (!arst_n)
    (tck_rise && tap == jdbg_pkg::CAP_DR && ir == `JDBG_IR_BUS) |=> dr_sh[0] == $past(res.valid))
    else $error("scan-out not previous result");
  a_addr_fault: assert property (@(posedge mclk) disable iff (!arst_n)
    (done && req.addr > `JDBG_A_PCHI) |=> !res.ok && res.err == jdbg_pkg::ERR_ADDR)
    else $error("unmapped address not faulted");
endmodule

// ==== jdbg_port_tb_top.sv ====
// Purpose: self-checking bench for the debug access port
// Assumes: core and segment side modelled here, probe in jdbg_probe
// Notes:   every bus-access scan returns the previous transaction's result, with valid clear while that transaction is still pending
`timescale 1ns/1ps
`include "jdbg_defines.svh"
module jdbg_port_tb_top;
  logic        mclk, arst_n, tck, tms, tdi, tdo, debug_mode, bkpt_event, reset_event, debug_req;
  logic        xchg_valid, xchg_take, core_store, seg_err, take_en, tdo_oe, seg_rd, seg_wr;
  logic [63:0] pc_sample;
  logic [31:0] xchg_data, core_store_data, seg_addr, seg_rdata, taken, seg_wdata, seg_wlast;
  int          fails, n_tests, seg_rd_n;
  jdbg_pkg::jdbg_rsp_s r;

  jdbg_port dut_u (.mclk(mclk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .debug_mode(debug_mode), .bkpt_event(bkpt_event), .reset_event(reset_event), .debug_req(debug_req),
    .pc_sample(pc_sample), .xchg_data(xchg_data), .xchg_valid(xchg_valid), .xchg_take(xchg_take),
    .core_store(core_store), .core_store_data(core_store_data), .seg_addr(seg_addr), .seg_rd(seg_rd),
    .seg_wr(seg_wr), .seg_wdata(seg_wdata), .seg_rdata(seg_rdata), .seg_err(seg_err));
  jdbg_probe probe_u (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // core side: segment data follows the address, instructions taken when enabled
  always @(posedge mclk)
  begin
    seg_rdata <= seg_addr ^ 32'h5a5a_0000;
    xchg_take <= xchg_valid && take_en && !xchg_take;
    if (xchg_take)
      taken <= xchg_data;
    if (seg_wr)
      seg_wlast <= seg_wdata;
    if (seg_rd)
      seg_rd_n <= seg_rd_n + 1;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [35:0] good(input logic [31:0] d);
    return {d, 4'h3};
  endfunction

  task automatic bus(input logic ex, input logic rd, input logic [7:0] a, input logic [31:0] d);
    jdbg_pkg::jdbg_req_s q;
    logic [41:0] o;
    q = '{data: d, addr: a, dir: rd, exec: ex};
    probe_u.scan(1'b0, 42, q, o);
    r = {o[41:10], o[3:0]};
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (xchg_valid !== 1'b0 && k < 200)
    begin
      @(posedge mclk);
      k++;
    end
    if (k == 200)
    begin
      fails++;
      summarize();
    end
  endtask

  task automatic t_devsel;
    logic [41:0] o;
    probe_u.scan(1'b1, 4, 42'h2, o);
    chk("ir_capture", 36'h1, o[3:0]);
    probe_u.scan(1'b0, 32, 42'h7f, o);
    probe_u.scan(1'b0, 32, 42'hff, o);
    probe_u.scan(1'b1, 4, 42'h3, o);
    bus(1'b1, 1'b1, `JDBG_A_CSR, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    chk("other_device", 36'h0, r[0]);
    probe_u.scan(1'b1, 4, 42'h2, o);
    probe_u.scan(1'b0, 32, 42'h0, o);
    chk("devsel_read", 36'h80, o[31:0]);
    probe_u.scan(1'b1, 4, 42'h3, o);
    chk("tdo_oe_idle", 36'h0, tdo_oe);
  endtask

  task automatic t_csr;
    debug_mode <= 1'b1;
    bkpt_event <= 1'b1;
    @(posedge mclk);
    bkpt_event <= 1'b0;
    bus(1'b1, 1'b0, `JDBG_A_CSR, 32'h8);
    bus(1'b1, 1'b1, `JDBG_A_CSR, 32'h0);
    chk("csr_write", 36'h3, r[3:0]);
    chk("debug_req", 36'h1, debug_req);
    reset_event <= 1'b1;
    bus(1'b1, 1'b0, `JDBG_A_CSR, 32'he);
    chk("csr_read", good(32'hb), r);
    reset_event <= 1'b0;
    bus(1'b1, 1'b1, `JDBG_A_CSR, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    chk("csr_w1c", good(32'hd), r);
  endtask

  task automatic t_xchg;
    take_en <= 1'b0;
    bus(1'b1, 1'b0, `JDBG_A_XCHG, 32'h1111_0001);
    bus(1'b1, 1'b0, `JDBG_A_XCHG, 32'h2222_0002);
    chk("xchg_pending", 36'h0, r[0]);
    chk("xchg_data", 36'h1111_0001, xchg_data);
    chk("xchg_valid", 36'h1, xchg_valid);
    take_en <= 1'b1;
    wait_idle();
    chk("taken", 36'h1111_0001, taken);
    bus(1'b1, 1'b0, `JDBG_A_XCHG, 32'h2222_0002);
    chk("xchg_done", 36'h3, r[3:0]);
    wait_idle();
    chk("taken", 36'h2222_0002, taken);
    core_store <= 1'b1;
    core_store_data <= 32'hcafe_0004;
    @(posedge mclk);
    core_store <= 1'b0;
    bus(1'b1, 1'b1, `JDBG_A_XCHG, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    chk("xchg_read", good(32'hcafe_0004), r);
  endtask

  task automatic t_seg;
    bus(1'b1, 1'b0, `JDBG_A_SEGADDR, 32'h7f30_0000);
    bus(1'b1, 1'b1, `JDBG_A_SEGWIN, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    chk("seg_window", good(32'h256a_0000), r);
    chk("seg_addr", 36'h7f30_0000, seg_addr);
    bus(1'b1, 1'b0, `JDBG_A_SEGADDR, 32'h8000_0010);
    bus(1'b1, 1'b1, `JDBG_A_SEGWIN, 32'h0);
    bus(1'b1, 1'b1, `JDBG_A_SEGWIN, 32'h0);
    chk("seg_first", good(32'hda5a_0010), r);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    chk("seg_next", good(32'hda5a_0014), r);
    chk("seg_addr_inc", 36'h8000_0018, seg_addr);
    seg_err <= 1'b1;
    bus(1'b1, 1'b1, `JDBG_A_SEGWIN, 32'h0);
    seg_err <= 1'b0;
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    chk("seg_fault", 36'hd, r[3:0]);
    bus(1'b1, 1'b0, `JDBG_A_SEGWIN, 32'h1234_5678);
    chk("seg_write", 36'h1234_5678, seg_wlast);
    chk("seg_addr_wr", 36'h8000_0020, seg_addr);
    chk("seg_rd_count", 36'h4, seg_rd_n);
  endtask

  task automatic t_pc;
    pc_sample <= 64'h89ab_cdef_0123_4567;
    bus(1'b1, 1'b1, `JDBG_A_PCLO, 32'h0);
    pc_sample <= 64'h1111_2222_3333_4444;
    bus(1'b1, 1'b1, `JDBG_A_PCHI, 32'h0);
    chk("pc_low", good(32'h0123_4567), r);
    bus(1'b1, 1'b0, `JDBG_A_PCLO, 32'h0);
    chk("pc_high", good(32'h89ab_cdef), r);
    bus(1'b1, 1'b0, 8'h20, 32'h0);
    chk("ro_write", 36'h9, r[3:0]);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    chk("unmapped", 36'h5, r[3:0]);
  endtask

  initial
  begin
    {arst_n, debug_mode, bkpt_event, reset_event, core_store, seg_err, take_en} = '0;
    {pc_sample, core_store_data} = '0;
    fails = 0;
    n_tests = 0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    probe_u.tap_reset();
    t_devsel();
    t_csr();
    t_xchg();
    t_seg();
    t_pc();
    summarize();
  end
endmodule

// ==== jdbg_probe.sv ====
// Purpose: behavioural jtag probe driving the debug access port pins
// Assumes: tck 168 ns (21 mclk periods), moved only on mclk rising edges
// Notes:   tck stays low between scans; tdi idles high like a pulled-up pin
`timescale 1ns/1ps
module jdbg_probe (
  // clock
  input  wire logic mclk,
  // jtag pins
  output      logic tck,
  output      logic tms,
  output      logic tdi,
  input  wire logic tdo
);
  localparam int HALF = 10;

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one tck period; tdo sampled at the rising edge
  task automatic tick(input logic m, input logic d, output logic o);
    @(posedge mclk);
    tms <= m;
    tdi <= d;
    repeat (HALF) @(posedge mclk);
    tck <= 1'b1;
    o = tdo;
    repeat (HALF) @(posedge mclk);
    tck <= 1'b0;
  endtask

  task automatic tap_reset;
    logic o;
    repeat (5) tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
  endtask

  task automatic scan(input logic ir_sel, input int n, input logic [41:0] din, output logic [41:0] dout);
    logic o;
    dout = '0;
    tick(1'b1, 1'b1, o);
    if (ir_sel)
      tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
    tick(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
  endtask
endmodule
